// File: logic/scpc_pkg.sv
// Constants for the serial command power control block
// Function
// - Five-bit amplifier power register held
// - D7..D5 000 selects amplifier power register
// - Amp bit one powers up, ringer enables
// - Stand-by forces all amplifiers powered down
// - Register kept through stand-by, settings resume
// - Command 011100xx enters stand-by
// - Command 011110xx leaves stand-by
// - Reset places device in stand-by
// - Sequences timed by 8 kHz counter
// - Analog, clock, sigproc power-downs active high
// - Signal processor transfers unaffected by sequences
// - Normal operation about 30.5 ms after exit
// - Eight-bit commands over clock, data, strobe
// - LSB first, latched on strobe at clock rise
// - Extra clocks keep only last eight bits
package scpc_pkg;
	localparam int           CMD_W            = 8;
	localparam int           AMP_W            = 5;
	localparam logic [2:0]   AMP_SEL          = 3'h0;
	localparam logic [5:0]   STANDBY_ENTER    = 6'h1c;
	localparam logic [5:0]   STANDBY_EXIT     = 6'h1e;
	localparam logic [4:0]   AMP_RESET        = 5'h00;
	localparam int           MIC_BIT          = 4;
	localparam int           ACC_IN_BIT       = 3;
	localparam int           REC1_BIT         = 2;
	localparam int           ACC_OUT_BIT      = 1;
	localparam int           RING_BIT         = 0;
	// Sequence steps in frame sync ticks; 244 ticks of 125 us is 30.5 ms
	localparam int           POWERUP_TIME_US  = 30500;
	localparam int           TICK_US          = 125;
	localparam int           POWERUP_TICKS    = POWERUP_TIME_US / TICK_US;
	localparam logic [7:0]   ANA_UP_TICK      = 8'h01;
	localparam logic [7:0]   CLK_UP_TICK      = 8'h02;
	localparam logic [7:0]   DSP_UP_TICK      = 8'h03;
	localparam logic [7:0]   DONE_TICK        = 8'(POWERUP_TICKS);
	localparam logic [7:0]   DSP_DN_TICK      = 8'h01;
	localparam logic [7:0]   CLK_DN_TICK      = 8'h02;
	localparam logic [7:0]   ANA_DN_TICK      = 8'h03;
	typedef enum logic [1:0] {SCPC_STANDBY, SCPC_RISING, SCPC_ACTIVE, SCPC_FALLING} scpc_state_t;
endpackage : scpc_pkg

// File: logic/scpc_top.sv
// Serial command receiver with amplifier power and stand-by sequencing
`timescale 1ns/100ps
`default_nettype none
module scpc_top
	import scpc_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic              cmd_clk_i,
	input  wire logic              cmd_serial_in_i,
	input  wire logic              cmd_strobe_i,
	input  wire logic              frame_sync_8k_i,
	output logic [AMP_W-1:0]       amp_enable_o,
	output logic                   standby_o,
	output logic                   ready_o,
	output logic                   analog_pd_o,
	output logic                   clock_gate_pd_o,
	output logic                   sigproc_pd_o
);
	logic [2:0]       cclk_sync_reg;
	logic [1:0]       data_sync_reg;
	logic [1:0]       strb_sync_reg;
	logic [2:0]       fs_sync_reg;
	logic [CMD_W-1:0] shift_reg;
	logic [CMD_W-1:0] shift_next;
	logic [AMP_W-1:0] amp_power_reg;
	logic [AMP_W-1:0] amp_power_next;
	scpc_state_t      state_reg;
	scpc_state_t      state_next;
	logic [7:0]       count_reg;
	logic [7:0]       count_next;
	logic             ana_pd_reg;
	logic             ana_pd_next;
	logic             clk_pd_reg;
	logic             clk_pd_next;
	logic             dsp_pd_reg;
	logic             dsp_pd_next;
	logic [AMP_W-1:0] amp_out_reg;
	logic [AMP_W-1:0] amp_out_next;
	logic             standby_reg;
	logic             standby_next;
	logic             ready_reg;
	logic             ready_next;
	logic             cclk_rise;
	logic             fs_rise;
	logic             latch;
	logic             enter_cmd;
	logic             exit_cmd;

	// Special command match on the upper six bits
	function automatic logic cmd_match(input logic [CMD_W-1:0] word, input logic [5:0] code);
		return word[7:2] == code;
	endfunction : cmd_match

	// One sequencer step
	function automatic logic [7:0] tick_inc(input logic [7:0] cnt);
		return cnt + 8'h01;
	endfunction : tick_inc

	// Data and strobe pass two flops, clock and frame sync three; edges seen only on the second and third
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			cclk_sync_reg <= 3'h0;
			data_sync_reg <= 2'h0;
			strb_sync_reg <= 2'h0;
			fs_sync_reg   <= 3'h0;
		end
		else
		begin
			cclk_sync_reg <= {cclk_sync_reg[1:0], cmd_clk_i};
			data_sync_reg <= {data_sync_reg[0], cmd_serial_in_i};
			strb_sync_reg <= {strb_sync_reg[0], cmd_strobe_i};
			fs_sync_reg   <= {fs_sync_reg[1:0], frame_sync_8k_i};
		end
	end

	assign cclk_rise = cclk_sync_reg[1] & ~cclk_sync_reg[2];
	assign fs_rise   = fs_sync_reg[1] & ~fs_sync_reg[2];
	assign latch     = cclk_rise & strb_sync_reg[1];
	assign enter_cmd = latch && cmd_match(shift_reg, STANDBY_ENTER);
	assign exit_cmd  = latch && cmd_match(shift_reg, STANDBY_EXIT);

	// Command shifter and amplifier power register
	always_comb
	begin
		shift_next     = shift_reg;
		amp_power_next = amp_power_reg;
		if (cclk_rise && !strb_sync_reg[1])
			shift_next = {data_sync_reg[1], shift_reg[CMD_W-1:1]};
		if (latch && shift_reg[7:5] == AMP_SEL)
			amp_power_next = shift_reg[AMP_W-1:0];
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			shift_reg     <= 8'h00;
			amp_power_reg <= AMP_RESET;
		end
		else
		begin
			shift_reg     <= shift_next;
			amp_power_reg <= amp_power_next;
		end
	end

	// Stand-by sequencer on frame sync ticks; serial transfers left untouched
	always_comb
	begin
		state_next  = state_reg;
		count_next  = count_reg;
		ana_pd_next = ana_pd_reg;
		clk_pd_next = clk_pd_reg;
		dsp_pd_next = dsp_pd_reg;
		unique case (state_reg)
			SCPC_STANDBY:
			begin
				if (exit_cmd)
				begin
					state_next = SCPC_RISING;
					count_next = 8'h00;
				end
			end
			SCPC_RISING:
			begin
				if (enter_cmd)
				begin
					state_next = SCPC_FALLING;
					count_next = 8'h00;
				end
				else if (fs_rise)
				begin
					count_next = tick_inc(count_reg);
					if (count_next == ANA_UP_TICK)
						ana_pd_next = 1'b0;
					if (count_next == CLK_UP_TICK)
						clk_pd_next = 1'b0;
					if (count_next == DSP_UP_TICK)
						dsp_pd_next = 1'b0;
					if (count_next == DONE_TICK)
						state_next = SCPC_ACTIVE;
				end
			end
			SCPC_ACTIVE:
			begin
				if (enter_cmd)
				begin
					state_next = SCPC_FALLING;
					count_next = 8'h00;
				end
			end
			SCPC_FALLING:
			begin
				if (exit_cmd)
				begin
					state_next = SCPC_RISING;
					count_next = 8'h00;
				end
				else if (fs_rise)
				begin
					count_next = tick_inc(count_reg);
					if (count_next == DSP_DN_TICK)
						dsp_pd_next = 1'b1;
					if (count_next == CLK_DN_TICK)
						clk_pd_next = 1'b1;
					if (count_next == ANA_DN_TICK)
					begin
						ana_pd_next = 1'b1;
						state_next  = SCPC_STANDBY;
					end
				end
			end
		endcase
		// Amps follow register only in the active state
		if (state_next == SCPC_ACTIVE)
			amp_out_next = amp_power_next;
		else
			amp_out_next = '0;
		standby_next = (state_next == SCPC_STANDBY);
		ready_next   = (state_next == SCPC_ACTIVE);
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state_reg   <= SCPC_STANDBY;
			count_reg   <= 8'h00;
			ana_pd_reg  <= 1'b1;
			clk_pd_reg  <= 1'b1;
			dsp_pd_reg  <= 1'b1;
			amp_out_reg <= '0;
			standby_reg <= 1'b1;
			ready_reg   <= 1'b0;
		end
		else
		begin
			state_reg   <= state_next;
			count_reg   <= count_next;
			ana_pd_reg  <= ana_pd_next;
			clk_pd_reg  <= clk_pd_next;
			dsp_pd_reg  <= dsp_pd_next;
			amp_out_reg <= amp_out_next;
			standby_reg <= standby_next;
			ready_reg   <= ready_next;
		end
	end

	assign amp_enable_o    = amp_out_reg;
	assign standby_o       = standby_reg;
	assign ready_o         = ready_reg;
	assign analog_pd_o     = ana_pd_reg;
	assign clock_gate_pd_o = clk_pd_reg;
	assign sigproc_pd_o    = dsp_pd_reg;
endmodule : scpc_top
`default_nettype wire

// File: testbench/scpc_properties.sv
// Port checker for the serial command power control block
`timescale 1ns/100ps
`default_nettype none
module scpc_properties
	import scpc_pkg::*;
(
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             frame_sync_8k_i,
	input  wire logic [AMP_W-1:0] amp_enable_o,
	input  wire logic             standby_o,
	input  wire logic             ready_o,
	input  wire logic             analog_pd_o,
	input  wire logic             clock_gate_pd_o,
	input  wire logic             sigproc_pd_o
);
	logic [15:0] tick_reg;
	logic [15:0] tick_next;
	logic        fs_reg;
	// Frame sync rises seen since stand-by was left
	always_comb tick_next = standby_o ? 16'h0000 : tick_reg + 16'(frame_sync_8k_i && !fs_reg);
	always_ff @(posedge clk_i or posedge rst_i)
		if (rst_i)
			{tick_reg, fs_reg} <= '0;
		else
			{tick_reg, fs_reg} <= {tick_next, frame_sync_8k_i};
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_all_pd; analog_pd_o && clock_gate_pd_o && sigproc_pd_o; endsequence
	sequence s_no_pd; !analog_pd_o && !clock_gate_pd_o && !sigproc_pd_o; endsequence
	property p_rst; $fell(rst_i) |-> standby_o && !ready_o && !amp_enable_o ##0 s_all_pd; endproperty
	a_rst: assert property (p_rst) else $error("bad state after reset");
	property p_amp_off; !ready_o [*2] |-> amp_enable_o == 5'h00; endproperty
	a_amp_off: assert property (p_amp_off) else $error("amps on outside ready");
	property p_ready_pd; ready_o |-> s_no_pd; endproperty
	a_ready_pd: assert property (p_ready_pd) else $error("power-down high while ready");
	property p_stby_pd; standby_o [*2] |-> s_all_pd; endproperty
	a_stby_pd: assert property (p_stby_pd) else $error("power-down low in stand-by");
	property p_up_ord; $fell(analog_pd_o) |-> clock_gate_pd_o && sigproc_pd_o; endproperty
	a_up_ord: assert property (p_up_ord) else $error("power-up order wrong");
	property p_dn_ord; $rose(sigproc_pd_o) |-> !analog_pd_o && !clock_gate_pd_o; endproperty
	a_dn_ord: assert property (p_dn_ord) else $error("power-down order wrong");
	property p_rise; $rose(ready_o) |-> tick_reg inside {[16'd243:16'd245]}; endproperty
	a_rise: assert property (p_rise) else $error("rise time wrong");
	property p_exit; $fell(standby_o) |-> !ready_o ##0 s_all_pd; endproperty
	a_exit: assert property (p_exit) else $error("stand-by exit not sequenced");
endmodule : scpc_properties
`default_nettype wire

// File: testbench/scpc_host.sv
// Host model: three-wire command link and frame sync
`timescale 1ns/100ps
`default_nettype none
module scpc_host
(
	output logic cmd_clk_o,
	output logic cmd_serial_in_o,
	output logic cmd_strobe_o,
	output logic frame_sync_8k_o
);
	initial {cmd_clk_o, cmd_serial_in_o, cmd_strobe_o, frame_sync_8k_o} = 4'h0;
	// Sped up from 8 kHz to keep the run short
	always #200 frame_sync_8k_o = ~frame_sync_8k_o;
	task automatic send(input logic [7:0] cmd, input int junk);
		for (int i = -junk; i < 8; i++)
		begin
			cmd_serial_in_o = (i < 0) ? ~cmd_serial_in_o : cmd[i];
			#32 cmd_clk_o = 1'b1;
			#32 cmd_clk_o = 1'b0;
		end
		cmd_strobe_o = 1'b1;
		#32 cmd_clk_o = 1'b1;
		#32 cmd_clk_o = 1'b0;
		cmd_strobe_o = 1'b0;
		cmd_serial_in_o = ~cmd_serial_in_o;
	endtask : send
endmodule : scpc_host
`default_nettype wire

// File: testbench/scpc_top_bench.sv
// Self-checking bench for the serial command power control block
`timescale 1ns/100ps
`default_nettype none
module scpc_top_bench;
	import scpc_pkg::*;
	logic             clk_i = 1'b0;
	logic             rst_i = 1'b1;
	logic             cmd_clk_i, cmd_serial_in_i, cmd_strobe_i, frame_sync_8k_i;
	logic [AMP_W-1:0] amp_enable_o;
	logic             standby_o, ready_o, analog_pd_o, clock_gate_pd_o, sigproc_pd_o;
	integer           seed = 32'h9dce;
	int               n_errors = 0;
	int               samples_checked = 0;
	logic [4:0]       amp_exp = 5'h00;
	logic [7:0]       cmd;
	always #2.5 clk_i = ~clk_i;
	scpc_host u_host(.cmd_clk_o(cmd_clk_i), .cmd_serial_in_o(cmd_serial_in_i),
		.cmd_strobe_o(cmd_strobe_i), .frame_sync_8k_o(frame_sync_8k_i));
	scpc_top u_dut(.clk_i, .rst_i, .cmd_clk_i, .cmd_serial_in_i, .cmd_strobe_i, .frame_sync_8k_i,
		.amp_enable_o, .standby_o, .ready_o, .analog_pd_o, .clock_gate_pd_o, .sigproc_pd_o);
	function automatic logic [4:0] next_amp(input logic [7:0] c, input logic [4:0] old);
		return (c[7:5] == AMP_SEL) ? c[4:0] : old;
	endfunction : next_amp
	task automatic summarize;
		$display("checked %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : summarize
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic issue(input logic [7:0] c, input int junk);
		u_host.send(c, junk);
		repeat (6) @(posedge clk_i);
		#1;
	endtask : issue
	task automatic wait_up(input logic up);
		int k;
		k = 0;
		while ((up ? ready_o : standby_o) !== 1'b1 && k < 30000)
		begin
			@(posedge clk_i);
			#1;
			k++;
		end
		if (k == 30000)
		begin
			n_errors++;
			summarize();
		end
	endtask : wait_up
	initial
	begin
		repeat (3) @(posedge clk_i);
		#1 rst_i = 1'b0;
		chk({3'h0, standby_o, ready_o, analog_pd_o, clock_gate_pd_o, sigproc_pd_o}, 8'h17);
		chk({3'h0, amp_enable_o}, 8'h00);
		for (int ph = 0; ph < 3; ph++)
		begin
			for (int n = 0; n < 6; n++)
			begin
				cmd = 8'($random(seed));
				if (n == 0)
					cmd = 8'h17;
				if (cmd[7:5] == 3'h3)
					cmd[4] = 1'b0;
				if (cmd[7:5] == AMP_SEL && cmd[4])
					cmd[3] = 1'b0;
				amp_exp = next_amp(cmd, amp_exp);
				issue(cmd, n % 3);
				chk({3'h0, amp_enable_o}, ph == 1 ? {3'h0, amp_exp} : 8'h00);
			end
			issue({ph == 1 ? STANDBY_ENTER : STANDBY_EXIT, 2'($random(seed))}, 0);
			wait_up(ph != 1);
			repeat (2) @(posedge clk_i);
			#1;
			chk({3'h0, amp_enable_o}, ph == 1 ? 8'h00 : {3'h0, amp_exp});
			chk({3'h0, standby_o, ready_o, analog_pd_o, clock_gate_pd_o, sigproc_pd_o},
				ph == 1 ? 8'h17 : 8'h08);
		end
		// Mid-run reset from normal operation clears the register
		issue(8'h05, 1);
		chk({3'h0, amp_enable_o}, 8'h05);
		@(posedge clk_i);
		#1 rst_i = 1'b1;
		repeat (2) @(posedge clk_i);
		#1 rst_i = 1'b0;
		amp_exp = AMP_RESET;
		chk({3'h0, standby_o, ready_o, analog_pd_o, clock_gate_pd_o, sigproc_pd_o}, 8'h17);
		issue({STANDBY_EXIT, 2'h0}, 0);
		wait_up(1'b1);
		repeat (2) @(posedge clk_i);
		#1;
		chk({3'h0, amp_enable_o}, {3'h0, amp_exp});
		summarize();
	end
endmodule : scpc_top_bench
bind scpc_top scpc_properties u_props(.clk_i, .rst_i, .frame_sync_8k_i, .amp_enable_o,
	.standby_o, .ready_o, .analog_pd_o, .clock_gate_pd_o, .sigproc_pd_o);
`default_nettype wire
